// file: include/usb_otg_pkg.sv
// Package with register map, field positions, reset values and timing for the OTG status and power block.
package usb_otg_pkg;
    localparam logic [11:0] otg_line_status_addr   = 12'h000;
    localparam logic [11:0] otg_bus_control_addr   = 12'h004;
    localparam logic [11:0] usb_power_control_addr = 12'h008;

    localparam int cable_type_bit    = 7;
    localparam int line_steady_bit   = 5;
    localparam int session_valid_bit = 3;
    localparam int b_session_bit     = 2;
    localparam int a_power_bit       = 0;

    localparam int dplus_pu_bit   = 7;
    localparam int dminus_pu_bit  = 6;
    localparam int dplus_pd_bit   = 5;
    localparam int dminus_pd_bit  = 4;
    localparam int power_bit      = 3;
    localparam int sw_ctrl_bit    = 2;
    localparam int charge_bit     = 1;
    localparam int discharge_bit  = 0;

    localparam int act_pend_bit   = 7;
    localparam int guard_bit      = 4;
    localparam int busy_bit       = 3;
    localparam int suspend_bit    = 1;
    localparam int power_on_bit   = 0;

    localparam logic [7:0] bus_control_reset   = 8'h00;
    localparam logic [7:0] power_control_reset = 8'h00;
    localparam logic [7:0] bus_control_mask    = 8'hFF;
    localparam logic [7:0] power_control_wmask = 8'h13;

    localparam int clk_hz         = 40000000;
    localparam int steady_time_us = 1000;
    localparam int steady_cycles  = (clk_hz / 1000000) * steady_time_us;
    localparam int busy_time_us   = 1;
    localparam int busy_cycles    = (clk_hz / 1000000) * busy_time_us;
endpackage

// file: rtl/sync2.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
module sync2 #(
    parameter int width = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [width-1:0] async_in,
    output logic      [width-1:0] sync_out
);
    logic [width-1:0] meta_ff;
    logic [width-1:0] sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// file: rtl/usb_otg_status_power_ctrl.sv
// APB register bank for OTG line status, bus resistor and VBUS control, and module power control.
// Summary of operation
// - Cable-type bit: 1 none/B, 0 A cable.
// - Line-steady set after 1 ms unchanged lines.
// - Session-valid bit mirrors its comparator.
// - B session-end bit set below session valid.
// - A power-valid bit set above session valid.
// - Unimplemented bits ignore writes, read zero.
// - Control bits 7/6 enable D+/D- pull-ups.
// - Control bits 5/4 enable D+/D- pull-downs.
// - Software enable selects software or hardware resistors.
// - Power-on bit drives VBUS power switch.
// - Charge bit connects VBUS charging pull-up.
// - Discharge bit connects VBUS discharging pull-down.
// - Activity-pending shows detected, ungenerated activity interrupt.
// - Guard set blocks sleep on activity/pending.
// - Busy reads 1 until module ready.
// - Suspend gates 48 MHz clock, transceiver low power.
// - Power bit off: outputs inactive, analog off; sleep_block is not gated and still follows guard and activity.
//
// Added by the designer: the address map and the APB interface to the registers.
module usb_otg_status_power_ctrl #(
    parameter int steady_cycles = usb_otg_pkg::steady_cycles,
    parameter int busy_cycles   = usb_otg_pkg::busy_cycles
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cable_type_sense,
    input  wire logic        single_ended_zero,
    input  wire logic        j_state,
    input  wire logic        session_valid_cmp,
    input  wire logic        a_device_mode,
    input  wire logic        bus_activity,
    input  wire logic        activity_irq_taken,
    input  wire logic        hw_dplus_pullup,
    input  wire logic        hw_dminus_pullup,
    input  wire logic        hw_dplus_pulldown,
    input  wire logic        hw_dminus_pulldown,
    input  wire logic        core_active,
    output logic             dplus_pullup_en,
    output logic             dminus_pullup_en,
    output logic             dplus_pulldown_en,
    output logic             dminus_pulldown_en,
    output logic             bus_power_drive,
    output logic             bus_power_charge_en,
    output logic             bus_power_discharge_en,
    output logic             suspend_clock_gate,
    output logic             transceiver_low_power,
    output logic             module_enable,
    output logic             sleep_block
);
    localparam int cw = $clog2(steady_cycles + 1);
    localparam int bw = $clog2(busy_cycles + 1);

    logic [5:0] raw_in;
    logic [5:0] sync_in;
    logic       cable_s;
    logic       se0_s;
    logic       jst_s;
    logic       sesv_s;
    logic       amode_s;
    logic       act_s;

    // Cable, line and comparator levels come from the analog side.
    assign raw_in = {cable_type_sense, single_ended_zero, j_state, session_valid_cmp, a_device_mode,
                     bus_activity};
    sync2 #(.width(6)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_in),
        .sync_out (sync_in)
    );
    assign {cable_s, se0_s, jst_s, sesv_s, amode_s, act_s} = sync_in;

    logic [7:0]    bus_ctrl_ff;
    logic [7:0]    nxt_bus_ctrl;
    logic          guard_ff;
    logic          suspend_ff;
    logic          power_ff;
    logic          nxt_guard;
    logic          nxt_suspend;
    logic          nxt_power;
    logic [1:0]    line_prev_ff;
    logic [cw-1:0] steady_cnt_ff;
    logic [cw-1:0] nxt_steady_cnt;
    logic          line_steady_flag;
    logic          act_pend_ff;
    logic          nxt_act_pend;
    logic [bw-1:0] busy_cnt_ff;
    logic [bw-1:0] nxt_busy_cnt;
    logic          module_not_ready;
    logic [31:0]   prdata_ff;
    logic [31:0]   nxt_prdata;
    logic          pslverr_ff;
    logic          pready_ff;
    logic          nxt_pready;

    wire        setup       = psel && !penable;
    wire        acc_done    = psel && penable && pready_ff;
    wire        wr_en       = acc_done && pwrite && pstrb[0];
    wire        hit_status  = (paddr == usb_otg_pkg::otg_line_status_addr);
    wire        hit_control = (paddr == usb_otg_pkg::otg_bus_control_addr);
    wire        hit_power   = (paddr == usb_otg_pkg::usb_power_control_addr);
    wire        hit_any     = hit_status || hit_control || hit_power;
    wire [7:0]  wbyte       = pwdata[7:0];

    // Line-steady timer; any change of SE0 or J restarts the count.
    wire line_changed = (line_prev_ff != {se0_s, jst_s});
    assign nxt_steady_cnt = line_changed ? '0 :
                            (steady_cnt_ff == cw'(steady_cycles)) ? steady_cnt_ff : steady_cnt_ff + 1'b1;
    assign line_steady_flag = (steady_cnt_ff == cw'(steady_cycles));

    // Status word: only the documented bits are driven, the rest stay zero.
    wire [7:0] status_byte = {cable_s,
                              1'b0,
                              line_steady_flag,
                              1'b0,
                              sesv_s,
                              !amode_s && !sesv_s,
                              1'b0,
                              amode_s && sesv_s};

    // Pending is set by activity and cleared when the interrupt is generated; set wins.
    assign nxt_act_pend = act_s ? 1'b1 : (activity_irq_taken ? 1'b0 : act_pend_ff);

    // Busy counter keeps busy set after a power-off until the core is idle and busy_cycles have run out.
    assign nxt_busy_cnt = (power_ff || core_active) ? bw'(busy_cycles) :
                          (busy_cnt_ff != '0) ? busy_cnt_ff - 1'b1 : busy_cnt_ff;
    assign module_not_ready = power_ff || core_active || (busy_cnt_ff != '0);

    wire [7:0] power_byte = {act_pend_ff, 2'b00, guard_ff, module_not_ready, 1'b0, suspend_ff, power_ff};

    assign nxt_bus_ctrl = (wr_en && hit_control) ? (wbyte & usb_otg_pkg::bus_control_mask) : bus_ctrl_ff;
    // Only guard, suspend and power are writable; busy and pending are read-only.
    assign nxt_guard   = (wr_en && hit_power) ? wbyte[usb_otg_pkg::guard_bit] : guard_ff;
    assign nxt_suspend = (wr_en && hit_power) ? wbyte[usb_otg_pkg::suspend_bit] : suspend_ff;
    assign nxt_power   = (wr_en && hit_power) ? wbyte[usb_otg_pkg::power_on_bit] : power_ff;

    wire [7:0] rd_byte = hit_status ? status_byte : hit_control ? bus_ctrl_ff : hit_power ? power_byte : 8'h00;
    assign nxt_prdata = (setup && !pwrite) ? {24'h000000, rd_byte} : prdata_ff;
    // No wait state: ready rises in the first access cycle, the cycle after setup.
    assign nxt_pready = setup;

    // Resistor source select, then the power bit forces the resistor and VBUS enables inactive.
    wire sw_sel = bus_ctrl_ff[usb_otg_pkg::sw_ctrl_bit];
    wire dp_pu  = sw_sel ? bus_ctrl_ff[usb_otg_pkg::dplus_pu_bit]  : hw_dplus_pullup;
    wire dm_pu  = sw_sel ? bus_ctrl_ff[usb_otg_pkg::dminus_pu_bit] : hw_dminus_pullup;
    wire dp_pd  = sw_sel ? bus_ctrl_ff[usb_otg_pkg::dplus_pd_bit]  : hw_dplus_pulldown;
    wire dm_pd  = sw_sel ? bus_ctrl_ff[usb_otg_pkg::dminus_pd_bit] : hw_dminus_pulldown;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ctrl_ff   <= usb_otg_pkg::bus_control_reset;
            guard_ff      <= usb_otg_pkg::power_control_reset[usb_otg_pkg::guard_bit];
            suspend_ff    <= usb_otg_pkg::power_control_reset[usb_otg_pkg::suspend_bit];
            power_ff      <= usb_otg_pkg::power_control_reset[usb_otg_pkg::power_on_bit];
            line_prev_ff  <= 2'b00;
            steady_cnt_ff <= '0;
            act_pend_ff   <= 1'b0;
            busy_cnt_ff   <= '0;
        end else begin
            bus_ctrl_ff   <= nxt_bus_ctrl;
            guard_ff      <= nxt_guard;
            suspend_ff    <= nxt_suspend;
            power_ff      <= nxt_power;
            line_prev_ff  <= {se0_s, jst_s};
            steady_cnt_ff <= nxt_steady_cnt;
            act_pend_ff   <= nxt_act_pend;
            busy_cnt_ff   <= nxt_busy_cnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= setup && !hit_any;
        end
    end

    // Pin-facing outputs are registered so glitches from the select mux never reach the pads.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dplus_pullup_en        <= 1'b0;
            dminus_pullup_en       <= 1'b0;
            dplus_pulldown_en      <= 1'b0;
            dminus_pulldown_en     <= 1'b0;
            bus_power_drive        <= 1'b0;
            bus_power_charge_en    <= 1'b0;
            bus_power_discharge_en <= 1'b0;
            suspend_clock_gate     <= 1'b0;
            transceiver_low_power  <= 1'b0;
            module_enable          <= 1'b0;
            sleep_block            <= 1'b0;
        end else begin
            dplus_pullup_en        <= power_ff && dp_pu;
            dminus_pullup_en       <= power_ff && dm_pu;
            dplus_pulldown_en      <= power_ff && dp_pd;
            dminus_pulldown_en     <= power_ff && dm_pd;
            bus_power_drive        <= power_ff && bus_ctrl_ff[usb_otg_pkg::power_bit];
            bus_power_charge_en    <= power_ff && bus_ctrl_ff[usb_otg_pkg::charge_bit];
            bus_power_discharge_en <= power_ff && bus_ctrl_ff[usb_otg_pkg::discharge_bit];
            suspend_clock_gate     <= power_ff && suspend_ff;
            transceiver_low_power  <= !power_ff || suspend_ff;
            module_enable          <= power_ff;
            sleep_block            <= guard_ff && (act_s || act_pend_ff);
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
endmodule

// file: tb/usb_cable_model.sv
// Cable, line and VBUS comparator model for the far side of the block.
module usb_cable_model #(
    parameter int rise_ns = 100
) (
    input  wire logic dplus_pullup_en,
    input  wire logic dminus_pullup_en,
    input  wire logic bus_power_drive,
    input  wire logic bus_power_discharge_en,
    input  wire logic cable_b,
    input  wire logic remote_supply,
    output logic      cable_type_sense,
    output logic      a_device_mode,
    output logic      session_valid_cmp,
    output logic      single_ended_zero,
    output logic      j_state
);
    timeunit 1ns;
    timeprecision 1ps;
    // The sense pin floats high through its pull-up unless an A plug grounds it.
    assign cable_type_sense = cable_b;
    assign a_device_mode = !cable_b;
    assign j_state = dplus_pullup_en && !dminus_pullup_en;
    assign single_ended_zero = !dplus_pullup_en && !dminus_pullup_en;
    // VBUS takes time to cross the threshold, so the comparator lags its cause.
    assign #(rise_ns) session_valid_cmp = (bus_power_drive || remote_supply) && !bus_power_discharge_en;
endmodule

// file: tb/usb_otg_status_power_ctrl_props.sv
// Checker for bus timing and power gating of the OTG status and power block.
module usb_otg_status_power_ctrl_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dplus_pullup_en,
    input wire logic        dminus_pullup_en,
    input wire logic        dplus_pulldown_en,
    input wire logic        dminus_pulldown_en,
    input wire logic        bus_power_drive,
    input wire logic        bus_power_charge_en,
    input wire logic        bus_power_discharge_en,
    input wire logic        suspend_clock_gate,
    input wire logic        transceiver_low_power,
    input wire logic        module_enable,
    input wire logic        sleep_block
);
    default clocking @(posedge pclk); endclocking
    logic       live_ff;
    logic       cap_ff;
    // Outputs keep their reset values for one edge after release, so checks start one edge later.
    default disable iff (!presetn || !live_ff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            live_ff <= 1'b0;
        else
            live_ff <= 1'b1;
    end
    wire        wr_pwr = psel && penable && pready && pwrite && paddr == 12'h008 && pstrb[0];
    wire  [6:0] outs = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en,
                        bus_power_drive, bus_power_charge_en, bus_power_discharge_en};
    // Holds the written power bit so the check does not depend on what the bus shows later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cap_ff <= 1'b0;
        else if (wr_pwr)
            cap_ff <= pwdata[0];
    end
    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("No ready after setup.");
    a_ready_single: assert property (pready |=> !pready)
        else $error("Ready held too long.");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("Ready without setup.");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("Upper read bits not zero.");
    a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("Error response wrong.");
    a_off_quiet: assert property (!module_enable ##1 !module_enable |-> outs == 7'h00)
        else $error("Outputs active while off.");
    a_off_lowpower: assert property (!module_enable ##1 !module_enable |-> transceiver_low_power)
        else $error("Transceiver awake while off.");
    a_gate_power: assert property (suspend_clock_gate |-> module_enable && transceiver_low_power)
        else $error("Suspend state inconsistent.");
    a_power_write: assert property (wr_pwr |=> ##[0:1] module_enable == cap_ff)
        else $error("Power bit not applied.");
    c_write: cover property (wr_pwr);
    c_error: cover property (pready && pslverr);
    c_sleep: cover property (sleep_block);
endmodule
bind usb_otg_status_power_ctrl usb_otg_status_power_ctrl_props u_props (.*);

// file: tb/usb_otg_status_power_ctrl_tb_top.sv
// Self-checking bench for the OTG status and power register block.
module usb_otg_status_power_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] v;
    logic cable_type_sense, single_ended_zero, j_state, session_valid_cmp, a_device_mode;
    logic bus_activity = 0, activity_irq_taken = 0, core_active = 0, cable_b = 1, remote_supply = 0;
    logic hw_dplus_pullup = 0, hw_dminus_pullup = 0, hw_dplus_pulldown = 0, hw_dminus_pulldown = 0;
    logic dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en;
    logic bus_power_drive, bus_power_charge_en, bus_power_discharge_en;
    logic suspend_clock_gate, transceiver_low_power, module_enable, sleep_block;
    wire [6:0] outs = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en,
                       bus_power_drive, bus_power_charge_en, bus_power_discharge_en};
    int failures = 0, tests_run = 0;
    usb_otg_status_power_ctrl #(.steady_cycles(20), .busy_cycles(4)) u_dut (.*);
    usb_cable_model u_cable (.*);
    always #12.5 pclk = ~pclk;
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            failures++;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    function automatic logic [31:0] stat(input logic c, input logic sv, input logic st);
        return {24'h0, c, 1'b0, st, 1'b0, sv, c & ~sv, 1'b0, ~c & sv};
    endfunction
    task automatic close_out();
        $display("Checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        idle(16);
        presetn <= 1'b1;
        rchk("control", 12'h004, 32'h0);
        rchk("power", 12'h008, 32'h0);
        xfer(1'b0, 12'h00C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        xfer(1'b1, 12'h000, 32'hFFFFFFFF);
        idle(30);
        rchk("status", 12'h000, stat(1'b1, 1'b0, 1'b1));
        xfer(1'b1, 12'h008, 32'hFFFFFF1F);
        rchk("power", 12'h008, 32'h1B);
        chk("suspend", 32'h3, {30'h0, suspend_clock_gate, transceiver_low_power});
        xfer(1'b1, 12'h008, 32'h11);
        idle(2);
        chk("suspend", 32'h0, {30'h0, suspend_clock_gate, transceiver_low_power});
        for (int i = 0; i < 8; i++) begin
            v = 8'h04 | (8'h01 << i);
            xfer(1'b1, 12'h004, {24'hFFFFFF, v});
            rchk("control", 12'h004, {24'h0, v});
            chk("outputs", {25'h0, v[7:3], v[1:0]}, {25'h0, outs});
        end
        {hw_dplus_pullup, hw_dminus_pullup, hw_dplus_pulldown, hw_dminus_pulldown} <= 4'hA;
        xfer(1'b1, 12'h004, 32'hF0);
        idle(2);
        chk("hw outputs", 32'h50, {25'h0, outs});
        xfer(1'b1, 12'h004, 32'h54);
        idle(2);
        chk("sw outputs", 32'h28, {25'h0, outs});
        idle(30);
        rchk("steady", 12'h000, stat(1'b1, 1'b0, 1'b1));
        xfer(1'b1, 12'h004, 32'h84);
        idle(6);
        rchk("restart", 12'h000, stat(1'b1, 1'b0, 1'b0));
        idle(30);
        rchk("steady", 12'h000, stat(1'b1, 1'b0, 1'b1));
        for (int j = 0; j < 4; j++) begin
            cable_b <= j[1];
            remote_supply <= j[0];
            idle(12);
            rchk("status", 12'h000, stat(j[1], j[0], 1'b1));
        end
        bus_activity <= 1'b1;
        idle(8);
        chk("sleep", 32'h1, {31'h0, sleep_block});
        rchk("pending", 12'h008, 32'h99);
        xfer(1'b1, 12'h008, 32'h01);
        idle(2);
        chk("sleep", 32'h0, {31'h0, sleep_block});
        bus_activity <= 1'b0;
        idle(4);
        activity_irq_taken <= 1'b1;
        idle(1);
        activity_irq_taken <= 1'b0;
        rchk("pending", 12'h008, 32'h09);
        core_active <= 1'b1;
        xfer(1'b1, 12'h004, 32'hFC);
        xfer(1'b1, 12'h008, 32'h00);
        idle(3);
        chk("off outputs", 32'h0, {25'h0, outs});
        rchk("busy", 12'h008, 32'h08);
        core_active <= 1'b0;
        rchk("settle", 12'h008, 32'h08);
        idle(10);
        rchk("idle", 12'h008, 32'h00);
        close_out();
    end
    initial begin
        #100us;
        failures++;
        close_out();
    end
endmodule
